// ==== pkg/cei_pkg.sv ====
/*
 Shared constants for the cache error attribute and injection block:
 register offsets, field positions, reset values, codes and states.
 Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
*/
`default_nettype none

package cei_pkg;

   // ------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_ATTR = 8'h00;
   localparam logic [7:0] OFS_INJ_CTL = 8'h04;
   localparam logic [7:0] OFS_INJ_LO = 8'h08;
   localparam logic [7:0] OFS_INJ_HI = 8'h0C;
   localparam logic [7:0] OFS_DET_DIS = 8'h10;
   localparam logic [7:0] OFS_CSR0 = 8'h14;
   localparam logic [7:0] OFS_INT_STATUS = 8'h18;
   localparam logic [7:0] OFS_INT_ENABLE = 8'h1C;
   localparam logic [7:0] OFS_INT_CLEAR = 8'h20;

   // ------------------------------------------------------------
   // Field positions (bit n of the 32..63 numbering is bit 63-n)
   // ------------------------------------------------------------
   localparam int ATTR_DW_LSB = 28;
   localparam int ATTR_SRC_LSB = 16;
   localparam int ATTR_KIND_LSB = 12;
   localparam int ATTR_VALID_BIT = 0;
   localparam int INJ_TAG_BIT = 16;
   localparam int INJ_MIRROR_BIT = 9;
   localparam int INJ_DATA_BIT = 8;
   localparam int INJ_MASK_LSB = 0;
   localparam int CSR0_PE_BIT = 0;
   localparam int EV_CAPTURED = 0;
   localparam int EV_LOST = 1;
   localparam int EV_W = 2;

   // ------------------------------------------------------------
   // Codes and reset values
   // ------------------------------------------------------------
   localparam logic [4:0] SRC_SNOOP = 5'h00;
   localparam logic [4:0] SRC_INST = 5'h10;
   localparam logic [4:0] SRC_DATA = 5'h11;
   localparam logic [1:0] KIND_SNOOP = 2'h0;
   localparam logic [1:0] KIND_WRITE = 2'h1;
   localparam logic [1:0] KIND_READ = 2'h2;
   localparam logic [1:0] KIND_NONE = 2'h3;
   localparam logic [31:0] RESET_WORD = 32'h00000000;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [1:0] HTRANS_IDLE = 2'h0;

   typedef enum logic {BUS_IDLE, BUS_DATA} cei_bus_e;

endpackage

`default_nettype wire

// ==== rtl/cei_data_injector.sv ====
/*
 Data array write stage: applies data masks, check-byte mirroring and
 check-bit masks to one doubleword write, one registered cycle.
 Assumes control inputs reflect the register state at the write cycle.
*/
`timescale 1ns/10ps
`default_nettype none

module cei_data_injector
   import cei_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Write from the cache
   input wire logic wr_in,
   input wire logic [63:0] data_in,
   input wire logic [7:0] check_in,
   // Injection control
   input wire logic inject,
   input wire logic mirror,
   input wire logic [63:0] data_mask,
   input wire logic [7:0] check_mask,
   // Write to the data array
   output logic wr_out,
   output logic [63:0] data_out,
   output logic [7:0] check_out
);

   logic [7:0] check_src;

   // Mirror first so the mask lands on the mirrored byte
   always_comb begin
      check_src = (inject && mirror) ? data_in[63:56] : check_in;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wr_out <= 1'b0;
         data_out <= '0;
         check_out <= RESET_BYTE;
      end else begin
         wr_out <= wr_in;
         // Masks act only with injection on, so clean writes pass intact
         data_out <= inject ? (data_in ^ data_mask) : data_in;
         check_out <= inject ? (check_src ^ check_mask) : check_src;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   chk_data_mask_flip: assert property (
      wr_in |=> data_out == ($past(data_in)
         ^ ($past(inject) ? $past(data_mask) : 64'h0)))
      else $error("data mask not applied");

   chk_mirror_masked: assert property (
      wr_in && inject && mirror |=>
         check_out == ($past(data_in[63:56]) ^ $past(check_mask)))
      else $error("mirrored check byte wrong");

   chk_no_inject_pass: assert property (
      wr_in && !inject |=> check_out == $past(check_in)
         && data_out == $past(data_in))
      else $error("write altered without injection");

endmodule

`default_nettype wire

// ==== rtl/cei_error_attr_inject.sv ====
/*
 Cache error attribute capture and error injection control, with an
 AHB-Lite register slave and one level interrupt.
 Assumes error reports and array writes arrive on clk, one cycle each.
*/
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Data ECC errors record the doubleword index; other errors record zero.
// - Source code: 00000 snoop, 10000 instruction, 10001 data side.
// - Kind code: 00 snoop, 01 write, 10 read; 11 never produced.
// - First reported error fills attributes and sets capture_valid.
// - While capture_valid is set, attributes stay frozen until cleared.
// - Any injection active forces every detection enable on.
// - Tag inject bit inverts parity of each later tag write.
// - Mirror plus data inject copies data MSB onto check byte.
// - Data inject bit alters later data writes; clear means untouched.
// - Check mask applies to the mirrored byte when mirroring.
// - Check mask bits invert check bits only with data inject on.
// - Low and high data masks invert data bits while injecting.
module cei_error_attr_inject
   import cei_pkg::*;
#(
   parameter int DIS_W = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // Error report from detectors
   input wire logic err_valid,
   input wire logic err_reported,
   input wire logic err_data_ecc,
   input wire logic [2:0] err_dw,
   input wire logic err_snoop,
   input wire logic err_inst,
   input wire logic err_write,
   // Detection enables to the checkers
   output logic [DIS_W-1:0] detect_enable,
   // Tag array write path
   input wire logic tag_wr_in,
   input wire logic tag_par_in,
   output logic tag_wr_out,
   output logic tag_par_out,
   // Data array write path
   input wire logic data_wr_in,
   input wire logic [63:0] data_in,
   input wire logic [7:0] check_in,
   output logic data_wr_out,
   output logic [63:0] data_out,
   output logic [7:0] check_out,
   // Interrupt
   output logic irq
);

   // ------------------------------------------------------------
   // Bus slave
   // ------------------------------------------------------------
   cei_bus_e bus_state;
   logic [7:0] dp_addr;
   logic dp_write;
   logic wr_en;
   logic accept;
   logic [31:0] rd_word;

   // Any hsize except 3'h7 is accepted and treated as a word transfer
   assign accept = hsel && htrans[1] && hready && (hsize != 3'h7);
   assign wr_en = (bus_state == BUS_DATA) && dp_write;

   // One wait state per transfer keeps a read behind a write coherent
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         bus_state <= BUS_IDLE;
         dp_addr <= RESET_BYTE;
         dp_write <= 1'b0;
         hreadyout <= 1'b1;
      end else begin
         case (bus_state)
            BUS_IDLE: begin
               if (accept) begin
                  bus_state <= BUS_DATA;
                  dp_addr <= {haddr[7:2], 2'b00};
                  dp_write <= hwrite;
                  hreadyout <= 1'b0;
               end
            end
            BUS_DATA: begin
               bus_state <= BUS_IDLE;
               hreadyout <= 1'b1;
            end
            default: begin
               bus_state <= BUS_IDLE;
               hreadyout <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         hrdata <= RESET_WORD;
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
         if (bus_state == BUS_DATA && !dp_write) begin
            hrdata <= rd_word;
         end
      end
   end

   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   logic tag_inject_enable;
   logic check_byte_mirror_enable;
   logic data_inject_enable;
   logic [7:0] check_bit_inject_mask;
   logic [31:0] data_inject_mask_low;
   logic [31:0] data_inject_mask_high;
   logic [DIS_W-1:0] error_detect_disables;
   logic cache_parity_enable;
   logic [EV_W-1:0] int_enable;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tag_inject_enable <= 1'b0;
         check_byte_mirror_enable <= 1'b0;
         data_inject_enable <= 1'b0;
         check_bit_inject_mask <= RESET_BYTE;
         data_inject_mask_low <= RESET_WORD;
         data_inject_mask_high <= RESET_WORD;
         error_detect_disables <= '0;
         cache_parity_enable <= 1'b0;
         int_enable <= '0;
      end else if (wr_en) begin
         case (dp_addr)
            OFS_INJ_CTL: begin
               tag_inject_enable <= hwdata[INJ_TAG_BIT];
               check_byte_mirror_enable <= hwdata[INJ_MIRROR_BIT];
               data_inject_enable <= hwdata[INJ_DATA_BIT];
               check_bit_inject_mask <= hwdata[INJ_MASK_LSB +: 8];
            end
            OFS_INJ_LO: data_inject_mask_low <= hwdata;
            OFS_INJ_HI: data_inject_mask_high <= hwdata;
            OFS_DET_DIS: error_detect_disables <= hwdata[DIS_W-1:0];
            OFS_CSR0: cache_parity_enable <= hwdata[CSR0_PE_BIT];
            OFS_INT_ENABLE: int_enable <= hwdata[EV_W-1:0];
            default: begin
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Error attribute capture
   // ------------------------------------------------------------
   logic capture_valid;
   logic [2:0] error_doubleword_index;
   logic [4:0] error_txn_source;
   logic [1:0] error_txn_kind;
   logic sw_clear_valid;
   logic capture;
   logic lost;
   logic [4:0] next_source;
   logic [1:0] next_kind;

   assign sw_clear_valid = wr_en && (dp_addr == OFS_ATTR)
      && !hwdata[ATTR_VALID_BIT];
   // A report in the clearing cycle is captured, not lost
   assign capture = err_valid && err_reported
      && (!capture_valid || sw_clear_valid);
   assign lost = err_valid && err_reported && capture_valid
      && !sw_clear_valid;

   always_comb begin
      next_source = err_snoop ? SRC_SNOOP
         : (err_inst ? SRC_INST : SRC_DATA);
      next_kind = err_snoop ? KIND_SNOOP
         : (err_write ? KIND_WRITE : KIND_READ);
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         capture_valid <= 1'b0;
      end else if (capture) begin
         capture_valid <= 1'b1;
      end else if (sw_clear_valid) begin
         capture_valid <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         error_doubleword_index <= 3'h0;
         error_txn_source <= SRC_SNOOP;
         error_txn_kind <= KIND_SNOOP;
      end else if (capture) begin
         // Index means nothing for tag or parity errors
         error_doubleword_index <= err_data_ecc ? err_dw : 3'h0;
         error_txn_source <= next_source;
         error_txn_kind <= next_kind;
      end
   end

   // ------------------------------------------------------------
   // Interrupt status
   // ------------------------------------------------------------
   logic [EV_W-1:0] int_status;
   logic [EV_W-1:0] int_events;
   logic [EV_W-1:0] int_clear;

   assign int_events = {lost, capture};
   assign int_clear = (wr_en && dp_addr == OFS_INT_CLEAR)
      ? hwdata[EV_W-1:0] : '0;

   // Set wins over a clear in the same cycle
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         int_status <= '0;
         irq <= 1'b0;
      end else begin
         int_status <= (int_status & ~int_clear) | int_events;
         irq <= |(int_status & int_enable);
      end
   end

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   always_comb begin
      rd_word = RESET_WORD;
      case (dp_addr)
         OFS_ATTR: begin
            rd_word[ATTR_DW_LSB +: 3] = error_doubleword_index;
            rd_word[ATTR_SRC_LSB +: 5] = error_txn_source;
            rd_word[ATTR_KIND_LSB +: 2] = error_txn_kind;
            rd_word[ATTR_VALID_BIT] = capture_valid;
         end
         OFS_INJ_CTL: begin
            rd_word[INJ_TAG_BIT] = tag_inject_enable;
            rd_word[INJ_MIRROR_BIT] = check_byte_mirror_enable;
            rd_word[INJ_DATA_BIT] = data_inject_enable;
            rd_word[INJ_MASK_LSB +: 8] = check_bit_inject_mask;
         end
         OFS_INJ_LO: rd_word = data_inject_mask_low;
         OFS_INJ_HI: rd_word = data_inject_mask_high;
         OFS_DET_DIS: rd_word[DIS_W-1:0] = error_detect_disables;
         OFS_CSR0: rd_word[CSR0_PE_BIT] = cache_parity_enable;
         OFS_INT_STATUS: rd_word[EV_W-1:0] = int_status;
         OFS_INT_ENABLE: rd_word[EV_W-1:0] = int_enable;
         default: rd_word = RESET_WORD;
      endcase
   end

   // ------------------------------------------------------------
   // Detection enables and array write paths
   // ------------------------------------------------------------
   logic inject_active;

   assign inject_active = tag_inject_enable || data_inject_enable;

   // Forcing detection covers software that forgot its own setup
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         detect_enable <= '0;
      end else if (inject_active) begin
         detect_enable <= '1;
      end else begin
         detect_enable <= cache_parity_enable
            ? ~error_detect_disables : '0;
      end
   end

   // Control is sampled in the write cycle, so stored lines stay as is
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tag_wr_out <= 1'b0;
         tag_par_out <= 1'b0;
      end else begin
         tag_wr_out <= tag_wr_in;
         tag_par_out <= tag_par_in ^ tag_inject_enable;
      end
   end

   cei_data_injector u_data_inj (
      .clk(clk),
      .reset(reset),
      .wr_in(data_wr_in),
      .data_in(data_in),
      .check_in(check_in),
      .inject(data_inject_enable),
      .mirror(check_byte_mirror_enable),
      .data_mask({data_inject_mask_high, data_inject_mask_low}),
      .check_mask(check_bit_inject_mask),
      .wr_out(data_wr_out),
      .data_out(data_out),
      .check_out(check_out)
   );

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_report_free;
      err_valid && err_reported && !capture_valid;
   endsequence

   sequence s_held;
      capture_valid && !sw_clear_valid;
   endsequence

   chk_capture_sets_valid: assert property (
      s_report_free |=> capture_valid
         && error_txn_source == $past(next_source))
      else $error("first error not captured");

   chk_frozen_attrs: assert property (
      s_held |=> capture_valid && $stable(error_txn_source)
         && $stable(error_txn_kind) && $stable(error_doubleword_index))
      else $error("captured attributes overwritten");

   chk_dw_data_only: assert property (
      s_report_free ##0 !err_data_ecc |=> error_doubleword_index == 3'h0)
      else $error("index recorded for non data error");

   chk_src_codes: assert property (
      s_report_free ##0 !err_snoop |=> error_txn_source
         == ($past(err_inst) ? SRC_INST : SRC_DATA))
      else $error("unimplemented source code");

   chk_kind_codes: assert property (
      s_report_free ##0 err_snoop |=> error_txn_kind == KIND_SNOOP
         && error_txn_source == SRC_SNOOP && error_txn_kind != KIND_NONE)
      else $error("snoop kind wrong");

   chk_detect_forced: assert property (
      inject_active |=> &detect_enable)
      else $error("detection not forced during injection");

   chk_tag_parity_flip: assert property (
      tag_wr_in |=> tag_wr_out
         && tag_par_out == ($past(tag_par_in) ^ $past(tag_inject_enable)))
      else $error("tag parity injection wrong");

   chk_irq_follows: assert property (
      capture ##1 int_enable[EV_CAPTURED] |=> irq)
      else $error("interrupt missing after capture");

endmodule

`default_nettype wire

// ==== dv/cei_array_model.sv ====
/*
 Behavioural model of the cache tag and data arrays behind the block.
 Assumes one write per strobe cycle, on clk, straight from the block.
*/
`timescale 1ns/10ps
`default_nettype none

module cei_array_model (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Writes from the block
   input wire logic tag_wr,
   input wire logic tag_par,
   input wire logic data_wr,
   input wire logic [63:0] data,
   input wire logic [7:0] check,
   // Stored contents
   output logic stored_tag_par,
   output logic [63:0] stored_data,
   output logic [7:0] stored_check,
   output logic [15:0] write_count
);
   // ------------------------------------------------------------
   // Storage: keeps exactly what was last written, changed only by a write strobe or reset
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         stored_tag_par <= 1'h0;
         stored_data <= 64'h0;
         stored_check <= 8'h00;
         write_count <= 16'h0000;
      end else begin
         if (tag_wr) begin
            stored_tag_par <= tag_par;
         end
         if (data_wr) begin
            stored_data <= data;
            stored_check <= check;
         end
         // Counting writes exposes any spurious strobe
         if (tag_wr || data_wr) begin
            write_count <= write_count + 16'h0001;
         end
      end
   end
endmodule

`default_nettype wire

// ==== dv/test_cei_error_attr_inject.sv ====
/*
 Self-checking bench for the cache error attribute and injection block.
 Assumes the AHB-Lite slave is the only one, so hready is hreadyout.
*/
`timescale 1ns/10ps
`default_nettype none

module test_cei_error_attr_inject;
   import cei_pkg::*;
   logic clk, reset, hsel, hwrite, hready, hreadyout, hresp, irq;
   logic [31:0] haddr, hwdata, hrdata, rnd, rd, lo, hi, d1, d2, ctl, r, ea;
   logic [1:0] htrans;
   logic [2:0] hsize, err_dw;
   logic err_valid, err_reported, err_data_ecc, err_snoop, err_inst;
   logic err_write, tag_wr_in, tag_par_in, tag_wr_out, tag_par_out;
   logic data_wr_in, data_wr_out, m_tag, tg, inj, mir, sn, ins, ecc;
   logic [7:0] detect_enable, check_in, check_out, m_check;
   logic [63:0] data_in, data_out, m_data;
   logic [15:0] m_count, cnt0;
   logic [71:0] ex;
   int errors, n_checks, m, k, i;

   assign hready = hreadyout;

   cei_error_attr_inject #(.DIS_W(8)) dut_u (.clk(clk), .reset(reset),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .err_valid(err_valid), .err_reported(err_reported),
      .err_data_ecc(err_data_ecc), .err_dw(err_dw), .err_snoop(err_snoop),
      .err_inst(err_inst), .err_write(err_write),
      .detect_enable(detect_enable), .tag_wr_in(tag_wr_in),
      .tag_par_in(tag_par_in), .tag_wr_out(tag_wr_out),
      .tag_par_out(tag_par_out), .data_wr_in(data_wr_in),
      .data_in(data_in), .check_in(check_in), .data_wr_out(data_wr_out),
      .data_out(data_out), .check_out(check_out), .irq(irq));

   cei_array_model model_u (.clk(clk), .reset(reset), .tag_wr(tag_wr_out),
      .tag_par(tag_par_out), .data_wr(data_wr_out), .data(data_out),
      .check(check_out), .stored_tag_par(m_tag), .stored_data(m_data),
      .stored_check(m_check), .write_count(m_count));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
   endfunction

   function automatic logic [71:0] exp_write(input logic [63:0] d,
      input logic [7:0] c, input logic inj_on, input logic mir_on,
      input logic [63:0] dm, input logic [7:0] cm);
      if (!inj_on) begin
         return {d, c};
      end
      // Mirror uses the unmasked top byte, then the check mask on top
      return {d ^ dm, (mir_on ? d[63:56] : c) ^ cm};
   endfunction

   function automatic logic [31:0] exp_attr(input logic e, input logic s,
      input logic n, input logic w, input logic [2:0] dw);
      logic [4:0] src;
      logic [1:0] kind;
      src = s ? SRC_SNOOP : (n ? SRC_INST : SRC_DATA);
      kind = s ? KIND_SNOOP : (w ? KIND_WRITE : KIND_READ);
      return (32'(e ? dw : 3'h0) << ATTR_DW_LSB) |
         (32'(src) << ATTR_SRC_LSB) | (32'(kind) << ATTR_KIND_LSB) |
         32'h00000001;
   endfunction

   task automatic draw(output logic [31:0] v);
      rnd = lfsr(rnd);
      v = rnd;
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [63:0] exp,
      input logic [63:0] got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Bounded wait for hready sampled high at a rising edge
   task automatic wait_ready;
      for (int n = 0; n < 50; n++) begin
         @(posedge clk);
         if (hready === 1'b1) begin
            return;
         end
      end
      check("bus handshake", 64'h1, 64'h0);
      complete_run;
   endtask

   task automatic bus(input logic w, input logic [7:0] ofs,
      input logic [31:0] wd, output logic [31:0] rdat);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h000000, ofs};
      hwrite <= w;
      wait_ready;
      htrans <= HTRANS_IDLE;
      hsel <= 1'b0;
      hwdata <= wd;
      wait_ready;
      rdat = hrdata;
      check("bus response", 64'h0, 64'(hresp));
   endtask

   task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
      bus(1'b1, ofs, d, rd);
   endtask

   task automatic rdchk(input string what, input logic [7:0] ofs,
      input logic [31:0] exp);
      bus(1'b0, ofs, 32'h00000000, rd);
      check(what, 64'(exp), 64'(rd));
   endtask

   task automatic chk_detect(input logic pe, input logic [7:0] dis,
      input logic [31:0] c, input logic [7:0] exp);
      wr(OFS_CSR0, 32'(pe) << CSR0_PE_BIT);
      wr(OFS_DET_DIS, {24'h000000, dis});
      wr(OFS_INJ_CTL, c);
      repeat (2) @(posedge clk);
      check("detect enable", 64'(exp), 64'(detect_enable));
   endtask

   task automatic array_write(input logic [63:0] d, input logic [7:0] c,
      input logic tp);
      data_wr_in <= 1'b1;
      tag_wr_in <= 1'b1;
      data_in <= d;
      check_in <= c;
      tag_par_in <= tp;
      @(posedge clk);
      data_wr_in <= 1'b0;
      tag_wr_in <= 1'b0;
      data_in <= ~d;
      check_in <= ~c;
      repeat (2) @(posedge clk);
   endtask

   task automatic report(input logic rep, input logic e, input logic s,
      input logic n, input logic w, input logic [2:0] dw);
      err_valid <= 1'b1;
      err_reported <= rep;
      err_data_ecc <= e;
      err_snoop <= s;
      err_inst <= n;
      err_write <= w;
      err_dw <= dw;
      @(posedge clk);
      err_valid <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   // ------------------------------------------------------------
   // Clock and main sequence
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      {hsel, hwrite, err_valid, err_reported, err_data_ecc} = 5'h00;
      {err_snoop, err_inst, err_write, tag_wr_in, tag_par_in} = 5'h00;
      {data_wr_in, haddr, hwdata, err_dw} = 68'h0;
      {data_in, check_in} = 72'h0;
      htrans = HTRANS_IDLE;
      hsize = 3'h2;
      errors = 0;
      n_checks = 0;
      rnd = 32'hEBDA838E;
      reset = 1'b1;
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      rdchk("attr reset", OFS_ATTR, RESET_WORD);
      rdchk("inj ctl reset", OFS_INJ_CTL, RESET_WORD);
      wr(8'h40, 32'hFFFFFFFF);
      rdchk("unmapped", 8'h40, 32'h00000000);
      wr(OFS_INT_STATUS, 32'h00000003);
      rdchk("status read only", OFS_INT_STATUS, 32'h00000000);
      $display("test registers done");
      chk_detect(1'b1, 8'h00, 32'h0, 8'hFF);
      chk_detect(1'b1, 8'h3C, 32'h0, 8'hC3);
      chk_detect(1'b0, 8'h3C, 32'h0, 8'h00);
      chk_detect(1'b0, 8'h3C, 32'h1 << INJ_TAG_BIT, 8'hFF);
      chk_detect(1'b0, 8'h3C, 32'h1 << INJ_DATA_BIT, 8'hFF);
      chk_detect(1'b1, 8'h00, 32'h0, 8'hFF);
      $display("test detection done");
      for (m = 0; m < 4; m++) begin
         for (k = 0; k < 3; k++) begin
            draw(lo);
            draw(hi);
            draw(r);
            draw(d1);
            draw(d2);
            {mir, inj, tg} = {m[1], m[0], k[0]};
            ctl = (32'(tg) << INJ_TAG_BIT) | (32'(mir) << INJ_MIRROR_BIT) |
               (32'(inj) << INJ_DATA_BIT) | {24'h000000, r[7:0]};
            wr(OFS_INJ_LO, lo);
            wr(OFS_INJ_HI, hi);
            wr(OFS_INJ_CTL, ctl);
            rdchk("inj ctl", OFS_INJ_CTL, ctl);
            array_write({d1, d2}, r[15:8], r[16]);
            ex = exp_write({d1, d2}, r[15:8], inj, mir, {hi, lo}, r[7:0]);
            check("array data", ex[71:8], m_data);
            check("array check", 64'(ex[7:0]), 64'(m_check));
            check("tag parity", 64'(r[16] ^ tg), 64'(m_tag));
         end
      end
      wr(OFS_INJ_CTL, 32'h00000000);
      array_write(64'h0123456789ABCDEF, 8'h5A, 1'b0);
      cnt0 = m_count;
      wr(OFS_INJ_LO, 32'hFFFFFFFF);
      wr(OFS_INJ_HI, 32'h00000000);
      wr(OFS_INJ_CTL, 32'h000103FF);
      repeat (3) @(posedge clk);
      check("stored data", 64'h0123456789ABCDEF, m_data);
      check("write count", 64'(cnt0), 64'(m_count));
      array_write(64'h0123456789ABCDEF, 8'h5A, 1'b0);
      check("later data", 64'h0123456776543210, m_data);
      check("later check", 64'hFE, 64'(m_check));
      check("later tag", 64'h1, 64'(m_tag));
      wr(OFS_INJ_CTL, 32'h00000000);
      $display("test injection done");
      wr(OFS_INT_ENABLE, 32'h00000001);
      for (i = 0; i < 6; i++) begin
         draw(r);
         {ecc, sn, ins} = {r[0], i % 3 == 0, i % 3 == 1};
         report(1'b0, ecc, sn, ins, i[0], r[6:4]);
         bus(1'b0, OFS_ATTR, 32'h0, rd);
         check("valid unreported", 64'h0, 64'(rd[0]));
         report(1'b1, ecc, sn, ins, i[0], r[6:4]);
         ea = exp_attr(ecc, sn, ins, i[0], r[6:4]);
         rdchk("attr capture", OFS_ATTR, ea);
         check("irq raised", 64'h1, 64'(irq));
         report(1'b1, ~ecc, ~sn, ~ins, ~i[0], ~r[6:4]);
         rdchk("attr frozen", OFS_ATTR, ea);
         rdchk("status", OFS_INT_STATUS, 32'h00000003);
         wr(OFS_INT_ENABLE, 32'h00000000);
         @(posedge clk);
         check("irq masked", 64'h0, 64'(irq));
         wr(OFS_INT_ENABLE, 32'h00000001);
         wr(OFS_INT_CLEAR, 32'h00000003);
         wr(OFS_ATTR, 32'h00000000);
         check("irq cleared", 64'h0, 64'(irq));
      end
      $display("test capture done");
      complete_run;
   end
endmodule

`default_nettype wire
